// ===== shared/crtc_pkg.sv
// Package: register map, field positions, reset values and counts for the calendar clock
package crtc_pkg;
  // ---------------------------------------------------------------
  // Register word indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL0 = 6'h00;
  localparam logic [5:0] IDX_CTRL1 = 6'h01;
  localparam logic [5:0] IDX_TIME0 = 6'h02;
  localparam logic [5:0] IDX_TIME1 = 6'h03;
  localparam logic [5:0] IDX_DATE  = 6'h04;
  localparam logic [5:0] IDX_YEAR  = 6'h05;
  localparam logic [5:0] IDX_PSC   = 6'h06;
  localparam logic [5:0] IDX_ALARM = 6'h07;
  // ---------------------------------------------------------------
  // Key handling
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'ha5;
  localparam logic [7:0] KEY_READ_VALUE   = 8'h96;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_FLAG   = 0;
  localparam int BIT_IRQEN  = 1;
  localparam int BIT_STABLE = 4;
  localparam int BIT_HOLD   = 0;
  localparam int BIT_CAL    = 1;
  localparam int BIT_BCD    = 2;
  localparam int BIT_MATCH  = 7;
  // ---------------------------------------------------------------
  // Prescaler geometry
  // ---------------------------------------------------------------
  localparam logic [7:0] PS0_LAST    = 8'hff;
  localparam logic [6:0] PS1_LAST    = 7'h7f;
  localparam int         TAP_BIT     = 7;
  localparam logic [7:0] KEEPOUT_LO  = 8'h40;
  localparam logic [7:0] KEEPOUT_HI  = 8'hc0;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic       RST_HOLD  = 1'b1;
  localparam logic       RST_CAL   = 1'b1;
  localparam logic       RST_BCD   = 1'b0;
  localparam logic [7:0] RST_DAY   = 8'h01;
  localparam logic [7:0] RST_MON   = 8'h01;
  localparam logic [15:0] RST_YEAR = 16'h07d0;
endpackage

// ===== src/crtc_prescaler.sv
// Two cascaded prescalers fed by the synchronised low-frequency oscillator pin
`timescale 1ns/1ps
module crtc_prescaler (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        osc_pin,
  input  wire logic        hold,
  input  wire logic        clear,
  input  wire logic        load,
  input  wire logic [14:0] load_value,
  output logic      [14:0] count,
  output logic             sec_tick,
  output logic             time_stable
);
  logic [2:0] sync;
  logic       level;
  logic [7:0] ps0;
  logic [6:0] ps1;
  logic       next_level;
  logic [7:0] next_ps0;
  logic [6:0] next_ps1;
  logic       next_tick;
  logic       next_stable;
  logic       osc_rise;

  // ---------------------------------------------------------------
  // Pin synchroniser and counting
  // ---------------------------------------------------------------
  always_comb begin
    next_level = level;
    osc_rise   = 1'b0;
    if (sync[1] == sync[2] && sync[1] != level) begin
      next_level = sync[1];
      osc_rise   = sync[1];
    end
    next_ps0  = ps0;
    next_ps1  = ps1;
    next_tick = 1'b0;
    if (clear) begin
      next_ps0 = 8'h00;
      next_ps1 = 7'h00;
    end else if (load) begin
      next_ps0 = load_value[7:0];
      next_ps1 = load_value[14:8];
    end else if (osc_rise && !hold) begin
      next_ps0 = ps0 + 8'h01;
      // Tap falls as the first stage wraps, clocking the second
      if (ps0[crtc_pkg::TAP_BIT] && ps0 == crtc_pkg::PS0_LAST) begin
        next_ps1 = ps1 + 7'h01;
        if (ps1 == crtc_pkg::PS1_LAST) begin
          next_tick = 1'b1;
        end
      end
    end
    // Keep-out spans 64 oscillator periods either side of the update
    next_stable = !((ps1 == crtc_pkg::PS1_LAST && ps0 >= crtc_pkg::KEEPOUT_HI) ||
                    (ps1 == 7'h00 && ps0 < crtc_pkg::KEEPOUT_LO));
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync        <= 3'h0;
      level       <= 1'b0;
      ps0         <= 8'h00;
      ps1         <= 7'h00;
      sec_tick    <= 1'b0;
      time_stable <= 1'b0;
    end else begin
      sync        <= {sync[1:0], osc_pin};
      level       <= next_level;
      ps0         <= next_ps0;
      ps1         <= next_ps1;
      sec_tick    <= next_tick;
      time_stable <= next_stable;
    end
  end

  assign count = {ps1, ps0};
endmodule // crtc_prescaler

// ===== src/crtc_top.sv
// Calendar clock with alarm and key lock behind an APB slave
`timescale 1ns/1ps
module crtc_top (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        lowfreq_crystal_osc,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             alarm_irq
);
  logic        alarm_flag, alarm_irq_enable, count_hold, calendar_select, bcd_select;
  logic        unlocked;
  logic [7:0]  seconds_count, minutes_count, hours_count, weekday_count;
  logic [7:0]  day_of_month_count, month_count;
  logic [15:0] year_count;
  logic [7:0]  alarm_minutes, alarm_hours, alarm_weekday, alarm_day;

  logic        next_flag, next_irq_en, next_hold, next_cal, next_bcd, next_unlocked;
  logic [7:0]  next_sec, next_min, next_hour, next_dow, next_day, next_mon;
  logic [15:0] next_year;
  logic [7:0]  next_amin, next_ahour, next_adow, next_aday;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq;

  logic [14:0] ps_count;
  logic        sec_tick, time_stable;
  logic        ps_clear, ps_load;
  logic        access, wr;
  logic [5:0]  idx;
  logic        mapped;
  logic [31:0] image, merged;
  logic        key_wr, may_write;
  logic        advance, alarm_hit, any_enable;
  logic [7:0]  b_sec, b_min, b_hour, b_dow, b_day, b_mon;
  logic [15:0] b_year;

  // ---------------------------------------------------------------
  // Format helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bcd);
    to_bin = bcd ? 8'({4'h0, v[7:4]} * 8'd10 + {4'h0, v[3:0]}) : v;
  endfunction

  function automatic logic [7:0] to_fmt(input logic [7:0] b, input logic bcd);
    to_fmt = bcd ? {4'(b / 8'd10), 4'(b % 8'd10)} : b;
  endfunction

  function automatic logic [15:0] year_bin(input logic [15:0] v, input logic bcd);
    year_bin = bcd ? 16'({12'h0, v[15:12]} * 16'd1000 + {12'h0, v[11:8]} * 16'd100 +
                         {12'h0, v[7:4]} * 16'd10 + {12'h0, v[3:0]}) : v;
  endfunction

  function automatic logic [15:0] year_fmt(input logic [15:0] b, input logic bcd);
    year_fmt = bcd ? {4'(b / 16'd1000), 4'((b / 16'd100) % 16'd10),
                      4'((b / 16'd10) % 16'd10), 4'(b % 16'd10)} : b;
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m, input logic leap);
    case (m)
      8'd2:                    month_len = leap ? 8'd29 : 8'd28;
      8'd4, 8'd6, 8'd9, 8'd11: month_len = 8'd30;
      default:                 month_len = 8'd31;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // Prescalers
  // ---------------------------------------------------------------
  crtc_prescaler u_prescaler (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .osc_pin     (lowfreq_crystal_osc),
    .hold        (count_hold),
    .clear       (ps_clear),
    .load        (ps_load),
    .load_value  (merged[14:0]),
    .count       (ps_count),
    .sec_tick    (sec_tick),
    .time_stable (time_stable)
  );

  // ---------------------------------------------------------------
  // Bus decode and read image
  // ---------------------------------------------------------------
  always_comb begin
    access = psel && penable;
    wr     = access && pready && pwrite;
    idx    = paddr[7:2];
    mapped = (idx <= crtc_pkg::IDX_ALARM);
    image  = 32'h0;
    case (idx)
      crtc_pkg::IDX_CTRL0: begin
        image[15:8]                 = crtc_pkg::KEY_READ_VALUE;
        image[crtc_pkg::BIT_FLAG]   = alarm_flag;
        image[crtc_pkg::BIT_IRQEN]  = alarm_irq_enable;
        image[crtc_pkg::BIT_STABLE] = time_stable;
      end
      crtc_pkg::IDX_CTRL1: begin
        image[crtc_pkg::BIT_HOLD] = count_hold;
        image[crtc_pkg::BIT_CAL]  = calendar_select;
        image[crtc_pkg::BIT_BCD]  = bcd_select;
      end
      crtc_pkg::IDX_TIME0: image[15:0] = {minutes_count, seconds_count};
      crtc_pkg::IDX_TIME1: image[15:0] = {weekday_count, hours_count};
      crtc_pkg::IDX_DATE:  image[15:0] = {month_count, day_of_month_count};
      crtc_pkg::IDX_YEAR:  image[15:0] = year_count;
      crtc_pkg::IDX_PSC:   image[14:0] = ps_count;
      crtc_pkg::IDX_ALARM: image = {alarm_day, alarm_weekday, alarm_hours, alarm_minutes};
      default:             image = 32'h0;
    endcase
    merged = merge(image, pwdata, pstrb);
    // Key in the upper byte decides the lock for this very access too
    key_wr    = wr && idx == crtc_pkg::IDX_CTRL0 && pstrb[1];
    may_write = key_wr ? (pwdata[15:8] == crtc_pkg::UNLOCK_KEY_VALUE) : unlocked;
  end

  // ---------------------------------------------------------------
  // Calendar advance and alarm compare
  // ---------------------------------------------------------------
  always_comb begin
    advance = sec_tick && calendar_select && !count_hold &&
              !(wr && may_write && idx inside {[crtc_pkg::IDX_TIME0:crtc_pkg::IDX_YEAR]});
    b_sec   = to_bin(seconds_count, bcd_select);
    b_min   = to_bin(minutes_count, bcd_select);
    b_hour  = to_bin(hours_count, bcd_select);
    b_dow   = weekday_count;
    b_day   = to_bin(day_of_month_count, bcd_select);
    b_mon   = to_bin(month_count, bcd_select);
    b_year  = year_bin(year_count, bcd_select);
    if (b_sec >= 8'd59) begin
      b_sec = 8'd0;
      if (b_min >= 8'd59) begin
        b_min = 8'd0;
        if (b_hour >= 8'd23) begin
          b_hour = 8'd0;
          b_dow  = (b_dow >= 8'd6) ? 8'd0 : b_dow + 8'd1;
          if (b_day >= month_len(b_mon, b_year[1:0] == 2'b00)) begin
            b_day = 8'd1;
            if (b_mon >= 8'd12) begin
              b_mon  = 8'd1;
              b_year = b_year + 16'd1;
            end else begin
              b_mon = b_mon + 8'd1;
            end
          end else begin
            b_day = b_day + 8'd1;
          end
        end else begin
          b_hour = b_hour + 8'd1;
        end
      end else begin
        b_min = b_min + 8'd1;
      end
    end else begin
      b_sec = b_sec + 8'd1;
    end
    any_enable = alarm_minutes[crtc_pkg::BIT_MATCH] || alarm_hours[crtc_pkg::BIT_MATCH] ||
                 alarm_weekday[crtc_pkg::BIT_MATCH] || alarm_day[crtc_pkg::BIT_MATCH];
    alarm_hit = advance && any_enable && b_sec == 8'd0 &&
      (!alarm_minutes[crtc_pkg::BIT_MATCH] ||
       alarm_minutes[6:0] == to_fmt(b_min, bcd_select)) &&
      (!alarm_hours[crtc_pkg::BIT_MATCH] ||
       alarm_hours[6:0] == to_fmt(b_hour, bcd_select)) &&
      (!alarm_weekday[crtc_pkg::BIT_MATCH] || alarm_weekday[6:0] == b_dow[6:0]) &&
      (!alarm_day[crtc_pkg::BIT_MATCH] ||
       alarm_day[6:0] == to_fmt(b_day, bcd_select));
  end

  // ---------------------------------------------------------------
  // Register next state
  // ---------------------------------------------------------------
  always_comb begin
    next_flag     = alarm_flag;
    next_irq_en   = alarm_irq_enable;
    next_hold     = count_hold;
    next_cal      = calendar_select;
    next_bcd      = bcd_select;
    next_unlocked = unlocked;
    next_sec      = seconds_count;
    next_min      = minutes_count;
    next_hour     = hours_count;
    next_dow      = weekday_count;
    next_day      = day_of_month_count;
    next_mon      = month_count;
    next_year     = year_count;
    next_amin     = alarm_minutes;
    next_ahour    = alarm_hours;
    next_adow     = alarm_weekday;
    next_aday     = alarm_day;
    ps_clear      = 1'b0;
    ps_load       = 1'b0;
    if (key_wr) begin
      next_unlocked = may_write;
    end
    if (advance) begin
      next_sec  = to_fmt(b_sec, bcd_select);
      next_min  = to_fmt(b_min, bcd_select);
      next_hour = to_fmt(b_hour, bcd_select);
      next_dow  = b_dow;
      next_day  = to_fmt(b_day, bcd_select);
      next_mon  = to_fmt(b_mon, bcd_select);
      next_year = year_fmt(b_year, bcd_select);
    end
    // Locked writes fall through unseen, except to the alarm register; the bus still completes normally
    if (wr && may_write) begin
      case (idx)
        crtc_pkg::IDX_CTRL0: begin
          // Flag can only be cleared by software, never set
          next_flag   = alarm_flag && merged[crtc_pkg::BIT_FLAG];
          next_irq_en = merged[crtc_pkg::BIT_IRQEN];
        end
        crtc_pkg::IDX_CTRL1: begin
          next_hold = merged[crtc_pkg::BIT_HOLD];
          next_cal  = merged[crtc_pkg::BIT_CAL];
          next_bcd  = merged[crtc_pkg::BIT_BCD];
        end
        crtc_pkg::IDX_TIME0: begin
          {next_min, next_sec} = merged[15:0];
          ps_clear = 1'b1;
        end
        crtc_pkg::IDX_TIME1: begin
          {next_dow, next_hour} = merged[15:0];
          ps_clear = 1'b1;
        end
        crtc_pkg::IDX_DATE: begin
          {next_mon, next_day} = merged[15:0];
          ps_clear = 1'b1;
        end
        crtc_pkg::IDX_YEAR: begin
          next_year = merged[15:0];
          ps_clear  = 1'b1;
        end
        crtc_pkg::IDX_PSC: ps_load = 1'b1;
        default: ;
      endcase
    end
    if (wr && idx == crtc_pkg::IDX_ALARM) begin
      {next_aday, next_adow, next_ahour, next_amin} = merged;
    end
    // A match in the clearing cycle must not be lost
    if (alarm_hit) begin
      next_flag = 1'b1;
    end
    next_irq     = next_flag && next_irq_en;
    next_pready  = access && !pready;
    next_pslverr = access && !pready && !mapped;
    next_prdata  = (access && !pready && !pwrite) ? image : 32'h0;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alarm_flag         <= 1'b0;
      alarm_irq_enable   <= 1'b0;
      count_hold         <= crtc_pkg::RST_HOLD;
      calendar_select    <= crtc_pkg::RST_CAL;
      bcd_select         <= crtc_pkg::RST_BCD;
      unlocked           <= 1'b0;
      seconds_count      <= 8'h00;
      minutes_count      <= 8'h00;
      hours_count        <= 8'h00;
      weekday_count      <= 8'h00;
      day_of_month_count <= crtc_pkg::RST_DAY;
      month_count        <= crtc_pkg::RST_MON;
      year_count         <= crtc_pkg::RST_YEAR;
      alarm_minutes      <= 8'h00;
      alarm_hours        <= 8'h00;
      alarm_weekday      <= 8'h00;
      alarm_day          <= 8'h00;
      prdata             <= 32'h0;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
      alarm_irq          <= 1'b0;
    end else begin
      alarm_flag         <= next_flag;
      alarm_irq_enable   <= next_irq_en;
      count_hold         <= next_hold;
      calendar_select    <= next_cal;
      bcd_select         <= next_bcd;
      unlocked           <= next_unlocked;
      seconds_count      <= next_sec;
      minutes_count      <= next_min;
      hours_count        <= next_hour;
      weekday_count      <= next_dow;
      day_of_month_count <= next_day;
      month_count        <= next_mon;
      year_count         <= next_year;
      alarm_minutes      <= next_amin;
      alarm_hours        <= next_ahour;
      alarm_weekday      <= next_adow;
      alarm_day          <= next_aday;
      prdata             <= next_prdata;
      pready             <= next_pready;
      pslverr            <= next_pslverr;
      alarm_irq          <= next_irq;
    end
  end
endmodule // crtc_top

// ===== verification/crtc_props.sv
// Checker: bus handshake, read data, key readback and alarm output properties
`timescale 1ns/1ps
module crtc_props (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        lowfreq_crystal_osc,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        alarm_irq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ---------------------------------------------------------------
  // Handshake
  // ---------------------------------------------------------------
  a_ready_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready missing after one wait state");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_map: assert property (pready |-> pslverr == (paddr[7:2] > 6'h07))
    else $error("pslverr does not match the address map");
  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  a_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("read data driven outside a read answer");
  a_rdata_unmapped: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_key_read: assert property (pready && !pwrite && paddr[7:2] == 6'h00 |->
    prdata[15:8] == 8'h96)
    else $error("key byte read is not the constant");
  // Read data lags the flag by one register, so compare the output one cycle back
  a_irq_gate: assert property (pready && !pwrite && paddr[7:2] == 6'h00 |->
    $past(alarm_irq) == (prdata[0] && prdata[1]))
    else $error("alarm interrupt differs from flag and enable");
endmodule // crtc_props

// ===== verification/crtc_bench.sv
// Testbench: register access, key lock, calendar stepping and alarm of the calendar clock
`timescale 1ns/1ps
module crtc_bench;
  logic        clk_sys, reset_n, osc, psel, penable, pwrite, pready, pslverr, alarm_irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, seed, v;
  logic [3:0]  pstrb;
  int          err_total, comparisons;

  crtc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .lowfreq_crystal_osc(osc), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .alarm_irq(alarm_irq));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Idle cycle first, so a release never meets the next setup in one step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No assumed wait count; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask

  task automatic rdchk(input string name, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, 4'h0);
    check(name, rd, exp);
  endtask

  // Oscillator only toggles here; real rate would need a full second of system cycles
  task automatic osc_pulses(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      osc <= 1'b1;
      repeat (4) @(posedge clk_sys);
      osc <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask

  // Load a time just before a tick, let four oscillator edges finish the second
  task automatic run_tick(input logic [15:0] t0, t1, dt, yr, input logic bcd, ien,
                          input logic [31:0] alm, input logic [15:0] e0, e1, ed, ey,
                          input logic ef);
    wr(crtc_pkg::IDX_CTRL0, {16'h0, 8'ha5, 8'h00});
    wr(crtc_pkg::IDX_ALARM, 32'h0);
    wr(crtc_pkg::IDX_CTRL1, {29'h0, bcd, 2'b11});
    wr(crtc_pkg::IDX_YEAR, {16'h0, yr});
    wr(crtc_pkg::IDX_DATE, {16'h0, dt});
    wr(crtc_pkg::IDX_TIME1, {16'h0, t1});
    wr(crtc_pkg::IDX_TIME0, {16'h0, t0});
    rdchk("prescalers", crtc_pkg::IDX_PSC, 32'h0);
    wr(crtc_pkg::IDX_ALARM, alm);
    wr(crtc_pkg::IDX_CTRL0, {16'h0, 8'ha5, 6'h0, ien, 1'b0});
    wr(crtc_pkg::IDX_PSC, 32'h7ffc);
    wr(crtc_pkg::IDX_CTRL1, {29'h0, bcd, 2'b10});
    osc_pulses(6);
    wr(crtc_pkg::IDX_CTRL1, {29'h0, bcd, 2'b11});
    rdchk("time0", crtc_pkg::IDX_TIME0, {16'h0, e0});
    rdchk("time1", crtc_pkg::IDX_TIME1, {16'h0, e1});
    rdchk("date", crtc_pkg::IDX_DATE, {16'h0, ed});
    rdchk("year", crtc_pkg::IDX_YEAR, {16'h0, ey});
    rdchk("ctrl0", crtc_pkg::IDX_CTRL0, {16'h0, 8'h96, 6'h0, ien, ef});
    check("irq", {31'h0, alarm_irq}, {31'h0, ef & ien});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n, osc, psel, penable, pwrite, err} = 6'h0;
    {paddr, pwdata, pstrb, rd, v} = '0;
    seed = 32'h5b40;
    err_total = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdchk("ctrl0 reset", crtc_pkg::IDX_CTRL0, 32'h9600);
    rdchk("ctrl1 reset", crtc_pkg::IDX_CTRL1, 32'h3);
    rdchk("year reset", crtc_pkg::IDX_YEAR, 32'h07d0);
    wr(crtc_pkg::IDX_TIME0, rnd() & 32'h3b3b);
    wr(crtc_pkg::IDX_CTRL1, 32'h0);
    rdchk("locked time0", crtc_pkg::IDX_TIME0, 32'h0);
    rdchk("locked ctrl1", crtc_pkg::IDX_CTRL1, 32'h3);
    // Masks keep every alarm field inside its legal range
    v = (rnd() & 32'h9e8697bb) | 32'h01000000;
    wr(crtc_pkg::IDX_ALARM, v);
    rdchk("alarm open", crtc_pkg::IDX_ALARM, v);
    wr(crtc_pkg::IDX_ALARM, 32'h0);
    apb(1'b0, 6'h08 + 6'(rnd() % 56), 32'h0, 4'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    wr(crtc_pkg::IDX_CTRL0, 32'h0000a502);
    rdchk("word unlock", crtc_pkg::IDX_CTRL0, 32'h9602);
    wr(crtc_pkg::IDX_TIME0, 32'h0102);
    wr(crtc_pkg::IDX_CTRL1, 32'h1);
    wr(crtc_pkg::IDX_CTRL1, 32'h3);
    rdchk("mode switch", crtc_pkg::IDX_TIME0, 32'h0102);
    apb(1'b1, crtc_pkg::IDX_CTRL0, 32'h00003c00, 4'b0010);
    wr(crtc_pkg::IDX_TIME0, 32'h0);
    rdchk("relocked", crtc_pkg::IDX_TIME0, 32'h0102);
    run_tick(16'h3b3b, 16'h0617, 16'h021c, 16'h07e8, 0, 1, 0, 0, 0, 16'h021d, 16'h07e8, 0);
    run_tick(16'h3b3b, 16'h0617, 16'h021c, 16'h07e7, 0, 1, 0, 0, 0, 16'h0301, 16'h07e7, 0);
    run_tick(16'h3b3b, 16'h0317, 16'h0c1f, 16'h07e7, 0, 1, 0, 0, 16'h0400, 16'h0101, 16'h07e8,
             0);
    run_tick(16'h0e3b, 0, 16'h0101, 16'h07e8, 0, 1, 32'h8f, 16'h0f00, 0, 16'h0101, 16'h07e8,
             1);
    run_tick(16'h0e3b, 0, 16'h0101, 16'h07e8, 0, 0, 32'h8f, 16'h0f00, 0, 16'h0101, 16'h07e8,
             1);
    run_tick(16'h3b3b, 16'h0117, 16'h0101, 16'h07e8, 0, 1, 32'h00828080, 0, 16'h0200,
             16'h0102, 16'h07e8, 1);
    run_tick(16'h3b3b, 16'h0317, 16'h0101, 16'h07e8, 0, 1, 32'h00828080, 0, 16'h0400,
             16'h0102, 16'h07e8, 0);
    run_tick(16'h3b3b, 16'h0017, 16'h0104, 16'h07e8, 0, 1, 32'h85008080, 0, 16'h0100,
             16'h0105, 16'h07e8, 1);
    run_tick(16'h5959, 16'h0009, 16'h0101, 16'h2024, 1, 1, 0, 0, 16'h0010, 16'h0101,
             16'h2024, 0);
    run_tick(16'h3b3b, 16'h0009, 16'h0101, 16'h07e8, 0, 1, 0, 0, 16'h000a, 16'h0101,
             16'h07e8, 0);
    wr(crtc_pkg::IDX_PSC, 32'h4080);
    osc_pulses(4);
    rdchk("held prescalers", crtc_pkg::IDX_PSC, 32'h4080);
    apb(1'b0, crtc_pkg::IDX_CTRL0, 32'h0, 4'h0);
    check("stable", {31'h0, rd[4]}, 32'h1);
    wrap_up();
  end
endmodule // crtc_bench

bind crtc_top crtc_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
  .lowfreq_crystal_osc(lowfreq_crystal_osc), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .alarm_irq(alarm_irq));
